// file: contact_bank.sv
// Contact bank model driving the six terminal pins
`timescale 1ns/1ps
module contact_bank (
    input  wire logic       clk,
    input  wire logic [5:0] want,  // Levels asked for
    output logic      [5:0] pins   // Contact levels, high = closed
);
    // Contacts move one edge after a request, then stay put long
    // past the debounce delay because the bench holds each level
    always_ff @(posedge clk) begin
        pins <= want;
    end
endmodule

// file: terminal_decode.sv
// Input terminal function decoder for a motor drive
`timescale 1ns/1ps
// Operation
// - Block output at once while base block
// - Speed search when base block releases
// - Up/down step once, then repeat while held
// - Up and down together halt changes
// - Counter held cleared while reset input on
// - Run sequencer while its input is on
// - Pause suspends the running sequencer
// - Aux inputs disable matching aux motors
// - Emergency stop latches fault until reset
// - Current select: current on, voltage off
// - Aux select: aux on, voltage off
// - Both selects on: voltage, current, aux
// - Run commands from terminals or keypad
// - Auto ramp disable forces linear ramps
// - Forced stop needs fresh run command
// - Parameter lock rejects parameter writes
// - Closed loop disable turns off PID
// - Jog direction only while jog active
// - NC reset active on open contact
// - Second-source inputs pick second source
// - One-shot pulse starts sequencer, stop cancels
// - Shutoff coasts; release restarts from zero
// - Code zero has no effect
// - Reset clears latched fault once cause gone
// - Debounce in two-millisecond steps, one to twenty
module terminal_decode #(
    parameter int unsigned STEP_CYCLES   = terminal_decode_pkg::STEP_CYCLES,
    parameter int unsigned REPEAT_CYCLES =
        terminal_decode_pkg::REPEAT_CYCLES
) (
    input  wire logic        clk,
    input  wire logic        reset_n,
    input  wire logic [5:0]  term_level,       // Pins, high = closed
    input  wire logic [35:0] term_func,        // Six codes, input 0 low
    input  wire logic [4:0]  debounce_steps,   // 1..20 units of 2 ms
    input  wire logic        jog_active,       // External jog command
    input  wire logic        run_cmd,          // Run command level
    input  wire logic        stop_cmd,         // Stop command level
    input  wire logic        keypad_reset,     // Keypad reset key
    output logic             output_block_q,   // Coast, no output
    output logic             speed_search_q,   // Pulse: start search
    output logic             freq_up_q,        // Pulse: one step up
    output logic             freq_down_q,      // Pulse: one step down
    output logic             counter_clear_q,  // Hold counter cleared
    output logic             seq_run_q,        // Sequencer running
    output logic             seq_pause_q,      // Sequencer suspended
    output logic [2:0]       aux_disable_q,    // Aux motors 1..3 off
    output logic             external_fault_code_q, // Latched fault
    output logic             freq_src_force_q, // Terminal picks source
    output logic [1:0]       freq_src_q,       // Chosen analog source
    output logic             op_src_force_q,   // Terminal picks op src
    output logic             op_from_terminals_q, // Else keypad_unit
    output logic             linear_ramp_q,    // Force linear ramps
    output logic             forced_stop_q,    // Stop, no error
    output logic             run_permit_q,     // Run allowed
    output logic             param_lock_q,     // Writes rejected
    output logic             pid_disable_q,    // Closed loop off
    output logic             jog_reverse_q,    // Jog in reverse
    output logic             fault_reset_q,    // Pulse: reset faults
    output logic             second_freq_src_q,// Second freq source
    output logic             second_op_src_q,  // Second op source
    output logic             shutoff_q,        // Coast on shutoff
    output logic             restart_zero_q    // Pulse: restart at 0
);

    localparam int unsigned PW = $clog2(STEP_CYCLES + 1);
    localparam int unsigned RW = $clog2(REPEAT_CYCLES + 1);

    // --------------------------------------------------------------
    // Pin synchronisers and debounce tick
    // --------------------------------------------------------------
    logic [5:0]    sync1_q;   // First stage, read only by second
    logic [5:0]    sync2_q;   // Stable in clk domain
    logic [5:0]    stable_q;  // Debounced levels
    logic [PW-1:0] pre_q;     // Step prescaler
    logic          tick;      // One pulse per 2 ms step
    logic [4:0]    steps;     // Clamped debounce setting

    assign tick = (pre_q == PW'(STEP_CYCLES - 1));
    // Settings outside 1..20 are clamped rather than ignored
    assign steps = (debounce_steps < terminal_decode_pkg::STEPS_MIN) ?
                   terminal_decode_pkg::STEPS_MIN :
                   (debounce_steps > terminal_decode_pkg::STEPS_MAX) ?
                   terminal_decode_pkg::STEPS_MAX : debounce_steps;

    // Two flip-flops before any logic sees a pin
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            sync1_q <= 6'h00;
            sync2_q <= 6'h00;
            pre_q   <= '0;
        end else begin
            sync1_q <= term_level;
            sync2_q <= sync1_q;
            pre_q   <= tick ? '0 : pre_q + PW'(1);
        end
    end

    // Per-terminal debounce; shared tick trades up to one step of
    // jitter for a single wide counter
    for (genvar i = 0; i < 6; i++) begin : g_deb
        logic [4:0] cnt_q;  // Steps seen since level differed
        always_ff @(posedge clk or negedge reset_n) begin
            if (!reset_n) begin
                cnt_q       <= 5'h00;
                stable_q[i] <= 1'b0;
            end else if (sync2_q[i] == stable_q[i]) begin
                cnt_q <= 5'h00;
            end else if (tick) begin
                if (cnt_q + 5'h01 >= steps) begin
                    stable_q[i] <= sync2_q[i];
                    cnt_q       <= 5'h00;
                end else begin
                    cnt_q <= cnt_q + 5'h01;
                end
            end
        end
    end

    // --------------------------------------------------------------
    // Function lookup over the six terminals
    // --------------------------------------------------------------
    // True when some terminal holding code is active; NC inverts
    function automatic logic hit(input logic [5:0] code,
                                 input logic nc);
        logic r;
        r = 1'b0;
        for (int t = 0; t < 6; t++) begin
            if (term_func[t*6 +: 6] == code) begin
                r = r | (stable_q[t] ^ nc);
            end
        end
        return r;
    endfunction

    // True when code is given to any terminal
    function automatic logic used(input logic [5:0] code);
        logic r;
        r = 1'b0;
        for (int t = 0; t < 6; t++) begin
            r = r | (term_func[t*6 +: 6] == code);
        end
        return r;
    endfunction

    // --------------------------------------------------------------
    // Decoded functions (code zero matches nothing acted on)
    // --------------------------------------------------------------
    logic       bb_act, up_act, dn_act, cnt_act, run_act, pause_act;
    logic       estop_act, aci_act, aux_act, aci_used, aux_used;
    logic       fstop_act, rst_act, shot_act, shut_act;
    logic [2:0] aux_off;  // Aux motor disable requests

    // A process, not continuous assignments: the lookups read the
    // terminal state inside the functions, which a plain assign
    // would not wake on
    always_comb begin
        bb_act    = hit(terminal_decode_pkg::FN_BLOCK_NO, 1'b0) |
                    hit(terminal_decode_pkg::FN_BLOCK_NC, 1'b1);
        up_act    = hit(terminal_decode_pkg::FN_UP, 1'b0);
        dn_act    = hit(terminal_decode_pkg::FN_DOWN, 1'b0);
        cnt_act   = hit(terminal_decode_pkg::FN_CNT_CLR, 1'b0);
        run_act   = hit(terminal_decode_pkg::FN_SEQ_RUN, 1'b0);
        pause_act = hit(terminal_decode_pkg::FN_SEQ_PAUSE, 1'b0);
        estop_act = hit(terminal_decode_pkg::FN_ESTOP_NO, 1'b0) |
                    hit(terminal_decode_pkg::FN_ESTOP_NC, 1'b1);
        aci_act   = hit(terminal_decode_pkg::FN_SEL_ACI, 1'b0);
        aux_act   = hit(terminal_decode_pkg::FN_SEL_AUX, 1'b0);
        aci_used  = used(terminal_decode_pkg::FN_SEL_ACI);
        aux_used  = used(terminal_decode_pkg::FN_SEL_AUX);
        fstop_act = hit(terminal_decode_pkg::FN_FSTOP_NO, 1'b0) |
                    hit(terminal_decode_pkg::FN_FSTOP_NC, 1'b1);
        rst_act   = hit(terminal_decode_pkg::FN_RESET_NO, 1'b0) |
                    hit(terminal_decode_pkg::FN_RESET_NC, 1'b1);
        shot_act  = hit(terminal_decode_pkg::FN_SEQ_SHOT, 1'b0);
        shut_act  = hit(terminal_decode_pkg::FN_SHUT_NO, 1'b0) |
                    hit(terminal_decode_pkg::FN_SHUT_NC, 1'b1);
        for (int a = 0; a < 3; a++) begin
            aux_off[a] =
                hit(terminal_decode_pkg::FN_AUX1 + 6'(a), 1'b0);
        end
    end

    // --------------------------------------------------------------
    // Edge history and event state
    // --------------------------------------------------------------
    logic          bb_q;      // Base block seen last cycle
    logic          shut_q;    // Shutoff seen last cycle
    logic          shot_q;    // One-shot input last cycle
    logic          rst_q;     // Reset terminal input last cycle
    logic          run_q;     // Run command last cycle
    logic [1:0]    updn_q;    // Up/down pair last cycle
    logic [RW-1:0] rep_q;     // Repeat interval counter
    logic          oneshot_q; // Sequencer latched by one-shot

    // Only one direction counts; both together freeze frequency
    wire up_only  = up_act & ~dn_act;
    wire dn_only  = dn_act & ~up_act;
    wire updn_new = ({up_act, dn_act} != updn_q);
    wire rep_done = (rep_q == RW'(REPEAT_CYCLES - 1));
    wire step_now = updn_new | rep_done;

    wire shot_rise  = shot_act & ~shot_q;
    wire stop_any   = stop_cmd | fstop_act;
    wire reset_req  = (rst_act & ~rst_q) | keypad_reset;
    wire run_rise   = run_cmd & ~run_q;

    // One-shot latch: set wins over a stop in the same cycle
    wire oneshot_d  = shot_rise | (oneshot_q & ~stop_any);
    wire seq_run_d  = run_act | oneshot_d;

    // Fault stays while the cause stays; set beats reset
    wire fault_d    = estop_act |
                      (external_fault_code_q & ~reset_req);

    // Fresh run edge needed after a forced stop
    wire permit_d   = ~fstop_act & (run_rise |
                      (run_permit_q & ~stop_cmd));

    // Source priority: voltage, current, auxiliary
    wire [1:0] src_d =
        (aci_used & aux_used & aci_act & aux_act) ?
            terminal_decode_pkg::SRC_VOLT :
        (aci_used & aci_act) ? terminal_decode_pkg::SRC_CURR :
        (aux_used & aux_act) ? terminal_decode_pkg::SRC_AUX :
            terminal_decode_pkg::SRC_VOLT;

    // Edge history and latches
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            bb_q      <= 1'b0;
            shut_q    <= 1'b0;
            shot_q    <= 1'b0;
            rst_q     <= 1'b0;
            run_q     <= 1'b0;
            updn_q    <= 2'h0;
            rep_q     <= '0;
            oneshot_q <= 1'b0;
        end else begin
            bb_q      <= bb_act;
            shut_q    <= shut_act;
            shot_q    <= shot_act;
            rst_q     <= rst_act;
            run_q     <= run_cmd;
            updn_q    <= {up_act, dn_act};
            rep_q     <= (updn_new | rep_done) ? '0 : rep_q + RW'(1);
            oneshot_q <= oneshot_d;
        end
    end

    // --------------------------------------------------------------
    // Registered outputs
    // --------------------------------------------------------------
    // Every output leaves from a flip-flop, one cycle after decode
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            output_block_q        <= 1'b0;
            speed_search_q        <= 1'b0;
            freq_up_q             <= 1'b0;
            freq_down_q           <= 1'b0;
            counter_clear_q       <= 1'b0;
            seq_run_q             <= 1'b0;
            seq_pause_q           <= 1'b0;
            aux_disable_q         <= 3'h0;
            external_fault_code_q <= 1'b0;
            freq_src_force_q      <= 1'b0;
            freq_src_q            <= terminal_decode_pkg::SRC_VOLT;
            op_src_force_q        <= 1'b0;
            op_from_terminals_q   <= 1'b0;
            linear_ramp_q         <= 1'b0;
            forced_stop_q         <= 1'b0;
            run_permit_q          <= 1'b0;
            param_lock_q          <= 1'b0;
            pid_disable_q         <= 1'b0;
            jog_reverse_q         <= 1'b0;
            fault_reset_q         <= 1'b0;
            second_freq_src_q     <= 1'b0;
            second_op_src_q       <= 1'b0;
            shutoff_q             <= 1'b0;
            restart_zero_q        <= 1'b0;
        end else begin
            output_block_q        <= bb_act;
            speed_search_q        <= bb_q & ~bb_act;
            freq_up_q             <= up_only & step_now;
            freq_down_q           <= dn_only & step_now;
            counter_clear_q       <= cnt_act;
            seq_run_q             <= seq_run_d;
            seq_pause_q           <= seq_run_d & pause_act;
            aux_disable_q         <= aux_off;
            external_fault_code_q <= fault_d;
            freq_src_force_q      <= aci_used | aux_used;
            freq_src_q            <= src_d;
            op_src_force_q        <=
                used(terminal_decode_pkg::FN_OP_SRC);
            op_from_terminals_q   <=
                hit(terminal_decode_pkg::FN_OP_SRC, 1'b0);
            linear_ramp_q         <=
                hit(terminal_decode_pkg::FN_LIN_RAMP, 1'b0);
            forced_stop_q         <= fstop_act;
            run_permit_q          <= permit_d;
            param_lock_q          <=
                hit(terminal_decode_pkg::FN_LOCK, 1'b0);
            pid_disable_q         <=
                hit(terminal_decode_pkg::FN_PID_OFF, 1'b0);
            jog_reverse_q         <= jog_active &
                hit(terminal_decode_pkg::FN_JOG_DIR, 1'b0);
            fault_reset_q         <= reset_req;
            second_freq_src_q     <=
                hit(terminal_decode_pkg::FN_SRC2_FREQ, 1'b0);
            second_op_src_q       <=
                hit(terminal_decode_pkg::FN_SRC2_OP, 1'b0);
            shutoff_q             <= shut_act;
            restart_zero_q        <= shut_q & ~shut_act;
        end
    end

    // --------------------------------------------------------------
    // Assertions
    // --------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    property p_block;
        bb_act |=> output_block_q;
    endproperty
    a_block: assert property (p_block)
        else $error("base block did not cut output");

    property p_search;
        $fell(bb_act) |=> speed_search_q ##1 !speed_search_q;
    endproperty
    a_search: assert property (p_search)
        else $error("no single speed search pulse on release");

    property p_halt;
        (up_act && dn_act) [*2] |=> !freq_up_q && !freq_down_q;
    endproperty
    a_halt: assert property (p_halt)
        else $error("frequency moved with up and down both on");

    property p_step;
        $rose(up_only) |=> freq_up_q;
    endproperty
    a_step: assert property (p_step)
        else $error("up input gave no step");

    property p_counter;
        cnt_act |=> counter_clear_q;
    endproperty
    a_counter: assert property (p_counter)
        else $error("counter not held cleared");

    property p_pause;
        seq_pause_q |-> seq_run_q;
    endproperty
    a_pause: assert property (p_pause)
        else $error("pause without running sequencer");

    property p_fault;
        estop_act |=> external_fault_code_q;
    endproperty
    a_fault: assert property (p_fault)
        else $error("emergency stop did not latch fault");

    property p_prio;
        aci_used && aux_used && aci_act && aux_act |=>
            freq_src_q == terminal_decode_pkg::SRC_VOLT;
    endproperty
    a_prio: assert property (p_prio)
        else $error("source priority wrong");

    property p_forced;
        fstop_act |=> !run_permit_q ##1 (!run_permit_q || $past(run_rise));
    endproperty
    a_forced: assert property (p_forced)
        else $error("run allowed without fresh command");

    property p_jog;
        !jog_active |=> !jog_reverse_q;
    endproperty
    a_jog: assert property (p_jog)
        else $error("jog direction acted without jog");

    property p_shot;
        shot_rise && !stop_any ##1 !stop_any [*2] |=> seq_run_q;
    endproperty
    a_shot: assert property (p_shot)
        else $error("one-shot did not keep sequencer running");

    property p_restart;
        $fell(shut_act) |=> restart_zero_q && !shutoff_q;
    endproperty
    a_restart: assert property (p_restart)
        else $error("shutoff release gave no zero restart");

    c_fault_reset: cover property (external_fault_code_q ##1
                                   !external_fault_code_q);
    c_updn_repeat: cover property (freq_up_q ##[1:40] freq_up_q);
    c_block_cycle: cover property (output_block_q ##1 speed_search_q);

endmodule

// file: terminal_decode_pkg.sv
// Constants shared by the input terminal function decoder
package terminal_decode_pkg;

    // --------------------------------------------------------------
    // Terminal layout
    // --------------------------------------------------------------
    localparam int unsigned TERM_COUNT = 6;   // Six programmable inputs
    localparam int unsigned CODE_W     = 6;   // Function code width

    // --------------------------------------------------------------
    // Function codes
    // --------------------------------------------------------------
    localparam logic [5:0] FN_NONE      = 6'h00;  // No effect
    localparam logic [5:0] FN_RESET_NO  = 6'h05;  // External reset, NO
    localparam logic [5:0] FN_BLOCK_NO  = 6'h09;  // Output block, NO
    localparam logic [5:0] FN_BLOCK_NC  = 6'h0A;  // Output block, NC
    localparam logic [5:0] FN_UP        = 6'h0B;  // Frequency up
    localparam logic [5:0] FN_DOWN      = 6'h0C;  // Frequency down
    localparam logic [5:0] FN_CNT_CLR   = 6'h0D;  // Counter reset
    localparam logic [5:0] FN_SEQ_RUN   = 6'h0E;  // Run sequencer
    localparam logic [5:0] FN_SEQ_PAUSE = 6'h0F;  // Pause sequencer
    localparam logic [5:0] FN_AUX1      = 6'h10;  // Aux motor 1 disable
    localparam logic [5:0] FN_ESTOP_NO  = 6'h13;  // Emergency stop, NO
    localparam logic [5:0] FN_ESTOP_NC  = 6'h14;  // Emergency stop, NC
    localparam logic [5:0] FN_SEL_ACI   = 6'h15;  // Voltage/current select
    localparam logic [5:0] FN_SEL_AUX   = 6'h16;  // Voltage/aux select
    localparam logic [5:0] FN_OP_SRC    = 6'h17;  // Terminals/keypad
    localparam logic [5:0] FN_LIN_RAMP  = 6'h18;  // Auto ramp disable
    localparam logic [5:0] FN_FSTOP_NC  = 6'h19;  // Forced stop, NC
    localparam logic [5:0] FN_FSTOP_NO  = 6'h1A;  // Forced stop, NO
    localparam logic [5:0] FN_LOCK      = 6'h1B;  // Parameter lock
    localparam logic [5:0] FN_PID_OFF   = 6'h1C;  // Closed loop disable
    localparam logic [5:0] FN_JOG_DIR   = 6'h1D;  // Jog direction
    localparam logic [5:0] FN_RESET_NC  = 6'h1E;  // External reset, NC
    localparam logic [5:0] FN_SRC2_FREQ = 6'h1F;  // Second freq source
    localparam logic [5:0] FN_SRC2_OP   = 6'h20;  // Second op source
    localparam logic [5:0] FN_SEQ_SHOT  = 6'h21;  // One-shot sequencer
    localparam logic [5:0] FN_SHUT_NO   = 6'h23;  // Output shutoff, NO
    localparam logic [5:0] FN_SHUT_NC   = 6'h24;  // Output shutoff, NC

    // --------------------------------------------------------------
    // Frequency command sources
    // --------------------------------------------------------------
    localparam logic [1:0] SRC_VOLT = 2'h0;  // Voltage input
    localparam logic [1:0] SRC_CURR = 2'h1;  // Current input
    localparam logic [1:0] SRC_AUX  = 2'h2;  // Auxiliary input

    // --------------------------------------------------------------
    // Timing
    // --------------------------------------------------------------
    localparam int unsigned CLK_FREQ_KHZ   = 100000;  // 100 MHz
    localparam int unsigned STEP_TIME_MS   = 2;       // Debounce unit
    localparam int unsigned STEP_CYCLES    = STEP_TIME_MS * CLK_FREQ_KHZ;
    localparam int unsigned REPEAT_TIME_MS = 100;     // Up/down repeat
    localparam int unsigned REPEAT_CYCLES  =
        REPEAT_TIME_MS * CLK_FREQ_KHZ;
    localparam logic [4:0]  STEPS_MIN      = 5'h01;   // Least setting
    localparam logic [4:0]  STEPS_MAX      = 5'h14;   // Largest setting

endpackage

// file: testbench.sv
// Self-checking bench for the terminal function decoder
`timescale 1ns/1ps
module testbench;
    logic clk = 1'b0, reset_n = 1'b0, jog_active = 1'b0;
    logic run_cmd = 1'b0, stop_cmd = 1'b0, keypad_reset = 1'b0;
    logic [5:0]  want = 6'h00, term_level;  // Asked and real pins
    logic [35:0] term_func = 36'h0;        // Codes, terminal 0 low
    logic [4:0]  debounce_steps = 5'h01;   // Shortest delay
    logic output_block_q, speed_search_q, freq_up_q, freq_down_q;
    logic counter_clear_q, seq_run_q, seq_pause_q, freq_src_force_q;
    logic external_fault_code_q, op_src_force_q, op_from_terminals_q;
    logic linear_ramp_q, forced_stop_q, run_permit_q, param_lock_q;
    logic pid_disable_q, jog_reverse_q, fault_reset_q, shutoff_q;
    logic second_freq_src_q, second_op_src_q, restart_zero_q;
    logic [2:0] aux_disable_q;
    logic [1:0] freq_src_q;
    int num_errors = 0, checks = 0, ups = 0, dns = 0, sss = 0, u0, d0;
    int seed = 32'h92d4;
    // Model table: code, output bit, normally closed flag
    logic [5:0] cd [18] = '{6'h00, 6'h09, 6'h0A, 6'h0D, 6'h18, 6'h1B,
        6'h1C, 6'h1F, 6'h20, 6'h23, 6'h24, 6'h1A, 6'h19, 6'h10, 6'h11,
        6'h12, 6'h17, 6'h0E};
    int bi [18] = '{14, 0, 0, 1, 2, 3, 4, 5, 6, 7, 7, 8, 8, 9, 10, 11,
        12, 13};
    logic [17:0] nc = 18'h01404;
    wire [13:0] vec = {seq_run_q, op_from_terminals_q, aux_disable_q,
        forced_stop_q, shutoff_q, second_op_src_q, second_freq_src_q,
        pid_disable_q, param_lock_q, linear_ramp_q, counter_clear_q,
        output_block_q};
    // Short counts keep the run brief; expectations use these values
    terminal_decode #(.STEP_CYCLES(4), .REPEAT_CYCLES(16)) DUT (.*);
    contact_bank partner (.clk(clk), .want(want), .pins(term_level));
    always #5 clk = ~clk;
    // Pulse counters, sampled where the outputs have settled
    always @(posedge clk) begin
        if (freq_up_q === 1'b1) ups++;
        if (freq_down_q === 1'b1) dns++;
        if (speed_search_q === 1'b1) sss++;
    end
    task automatic w(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic chk(input logic [15:0] s, input logic [15:0] e);
        checks++;
        if (s !== e) begin
            num_errors++;
            $display("unexpected t=%0t got=%h exp=%h", $time, s, e);
        end
    endtask
    // Set terminal 0 code and level, then wait out the debounce
    task automatic set(input logic [5:0] c, input logic a, int n = 12);
        @(posedge clk);
        term_func[5:0] <= c;
        want[0] <= a;
        w(n);
    endtask
    // One-cycle strobe on a command input
    // k: 0 keypad reset, 1 run, 2 stop
    task automatic pls(input int k);
        @(posedge clk);
        if (k == 0) keypad_reset <= 1'b1;
        else if (k == 1) run_cmd <= 1'b1;
        else stop_cmd <= 1'b1;
        @(posedge clk);
        {keypad_reset, run_cmd, stop_cmd} <= 3'h0;
        w(3);
    endtask
    task automatic summarize;
        $display("checks=%0d errors=%0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // Watchdog: a hang counts as a mismatch
    initial begin
        w(20000);
        num_errors++;
        summarize;
    end
    initial begin
        w(8);
        reset_n <= 1'b1;
        // Each table code at both levels; terminals 2 to 5 random, code zero
        for (int i = 0; i < 18; i++)
            for (int a = 0; a < 2; a++) begin
                want[5:2] <= 4'($random(seed));
                set(cd[i], a[0]);
                chk(vec, (bi[i] < 14 && (a[0] ^ nc[i])) ? 1 << bi[i] : 0);
            end
        // Latched fault, reset refused while cause stands
        term_func[11:6] <= 6'h1E;
        want[1] <= 1'b1;
        set(6'h13, 1'b1);
        chk(external_fault_code_q, 1);
        pls(0);
        chk(external_fault_code_q, 1);
        set(6'h13, 1'b0);
        chk(external_fault_code_q, 1);
        want[1] <= 1'b0;
        w(12);
        chk(external_fault_code_q, 0);
        set(6'h13, 1'b1);
        set(6'h13, 1'b0);
        pls(0);
        chk(external_fault_code_q, 0);
        // Source selection and its priority
        term_func[11:6] <= 6'h16;
        for (int k = 0; k < 4; k++) begin
            want[1] <= k[1];
            set(6'h15, k[0]);
            chk(freq_src_q, k == 1 ? 1 : k == 2 ? 2 : 0);
            chk(freq_src_force_q, 1);
        end
        // Forced stop needs a fresh run command
        term_func[11:6] <= 6'h0F;
        set(6'h1A, 1'b0);
        pls(1);
        chk(run_permit_q, 1);
        set(6'h1A, 1'b1);
        set(6'h1A, 1'b0);
        chk(run_permit_q, 0);
        pls(1);
        chk(run_permit_q, 1);
        // One-shot sequencer, pause, stop cancels
        set(6'h21, 1'b1);
        set(6'h21, 1'b0);
        want[1] <= 1'b1;
        w(12);
        chk({seq_run_q, seq_pause_q}, 2'h3);
        pls(2);
        chk(seq_run_q, 0);
        // Jog direction only with jog active
        set(6'h1D, 1'b1);
        chk(jog_reverse_q, 0);
        jog_active <= 1'b1;
        w(3);
        chk(jog_reverse_q, 1);
        // Up alone repeats; up and down together halt
        term_func[11:6] <= 6'h00;
        set(6'h0B, 1'b1);
        u0 = ups;
        w(40);
        chk(ups - u0 >= 2, 1);
        term_func[11:6] <= 6'h0C;
        want[1] <= 1'b1;
        w(12);
        u0 = ups;
        d0 = dns;
        w(40);
        chk(ups - u0 + dns - d0, 0);
        // Up code removed: down alone now steps
        d0 = dns;
        term_func[5:0] <= 6'h00;
        w(20);
        chk(dns - d0 >= 1, 1);
        // Longest debounce, then block release starts one search
        want[1] <= 1'b0;
        want[0] <= 1'b0;
        w(12);
        debounce_steps <= 5'h14;
        set(6'h09, 1'b1, 60);
        chk(output_block_q, 0);
        w(30);
        chk(output_block_q, 1);
        u0 = sss;
        set(6'h09, 1'b0, 100);
        chk(sss - u0, 1);
        summarize;
    end
endmodule
